// >>> relay_self_supervision.sv
// relay self-supervision: watchdog, fault-status output, diagnostic groups and status registers
// Function
// - watchdog supervises controller, restarts it when inoperable
// - failed restart raises permanent internal fault signal
// - permanent fault blocks all outputs except fault-status
// - internal supply voltages are monitored
// - fault-status energized only when supplied and healthy
// - extra alarm sources routable through output matrix
// - alarms assigned to groups; group ORs its alarms
// - groups selectable onto fault-status; reset selects group two
// - each group alarm mappable to any output
// - boot self-tests and continued runtime checking
// - permanent state drops contact, lights LED, shows message
// - permanent state entered when main functions fail
// - temporary fault sets matrix signal, logs on-event
// - temporary fault clearing logs off-event
// - front panel reset clears latched diagnostic state
// - four 16-bit diagnostic registers readable remotely
// - internal register bit0 voltage, bit9 low supply
// - bits 1-4 bus, order code, card, logic config
// - bits 5-8 arc unit, sensor, qd card, arc input
// - only on/off event code carried in self-diagnostic events
// - unexpected status lights LED and posts notice
`timescale 1ns/1ns
`default_nettype none

module relay_self_supervision
    import self_supervision_pkg::*;
#(
    parameter int KICK_TIMEOUT = KICK_TIMEOUT_CYC,    // watchdog timeout in cycles
    parameter int RESTART_PULSE = RESTART_PULSE_CYC,  // restart pulse in cycles
    parameter int RESTART_WAIT = RESTART_WAIT_CYC     // recovery window in cycles
) (
    input wire logic ref_clk,                            // 125 MHz system clock
    input wire logic rst,                                // synchronous reset, active high
    input wire logic wdKick,                             // controller alive pulse
    output logic controllerRestart,                      // restart pulse to controller
    output logic permanentFault,                         // permanent internal fault signal
    input wire logic auxSupplyOk,                        // auxiliary supply present
    input wire logic [INTERNAL_FAULT_BITS-1:0] hwFault,  // internal fault detectors
    input wire logic bootTestDone,                       // boot self-test finished
    input wire logic bootTestFail,                       // boot self-test failed
    input wire logic unexpectedStatus,                   // runtime checker saw odd status
    input wire logic [NUM_OUTPUTS-1:0] outputFault,      // per-output driver fault
    input wire logic [NUM_ALARMS-1:0] alarmIn,           // supervision alarm sources
    input wire logic [NUM_GROUPS-1:0] extraAlarmIn,      // link, extension, password alarms
    input wire logic [2*NUM_ALARMS-1:0] alarmGroupCfg,   // 2 bits per alarm: 0 none, 1..3 group
    input wire logic [NUM_GROUPS-1:0] groupToFaultCfg,   // group drives fault-status when set
    input wire logic groupToFaultLoad,                   // load strobe for groupToFaultCfg
    input wire logic [NUM_OUTPUTS-1:0] groupMatrixCfg [NUM_GROUPS], // group to output map
    input wire logic [NUM_OUTPUTS-1:0] extraMatrixCfg [NUM_GROUPS], // extra alarm to output map
    input wire logic [NUM_OUTPUTS-1:0] protectionOut,    // outputs asked by protection logic
    input wire logic panelReset,                         // front panel diagnostic reset
    input wire logic [1:0] regAddr,                      // remote register index
    input wire logic regRead,                            // remote read strobe
    output logic [REG_WIDTH-1:0] regData,                // remote read data
    output logic faultStatusOutput,                      // fault-status relay coil
    output logic [NUM_OUTPUTS-1:0] digitalOutput,        // relay output coils
    output logic [NUM_GROUPS-1:0] diagGroupAlarm,        // group alarms one to three
    output logic selfDiagSignal,                         // matrix signal of temporary fault
    output event_s diagEvent,                            // event toward the log
    output indication_s indication                       // LED and display requests
);

    // datapath:
    // - watchdog on
    //   the kick line
    // - alarms fold
    //   into groups
    // - matrix drive
    // - fault latches
    //   for the reader
    // - boot result
    //   latched once
    // outputs are all
    //   flops, so no
    //   glitch reaches
    //   a relay coil
    // watchdog state and counter
    wd_state_e wdState_q, wdState_d;
    logic [31:0] wdCount_q, wdCount_d;
    logic restart_q, restart_d;

    // latched diagnostic state and configuration
    logic [NUM_GROUPS-1:0] groupToFault_q;
    logic [INTERNAL_FAULT_BITS-1:0] faultLatch_q;
    logic [NUM_OUTPUTS-1:0] outFaultLatch_q;
    logic tempFault_q;
    logic bootBad_q;
    logic oddLatch_q;

    // map an alarm's group field to a one-hot group vector
    function automatic logic [NUM_GROUPS-1:0] group_hit(input logic [1:0] sel);
        group_hit = (sel == 2'h0) ? '0 : NUM_GROUPS'(1 << (sel - 2'h1));
    endfunction : group_hit

    // group field 0
    //   leaves the
    //   alarm unlinked,
    //   so a blank cfg
    //   never drops
    //   the fault relay
    // group OR across every alarm linked to it
    logic [NUM_GROUPS-1:0] groupActive;
    always_comb begin
        groupActive = '0;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            if (alarmIn[i]) begin
                groupActive = groupActive | group_hit(alarmGroupCfg[2*i +: 2]);
            end
        end
    end

    // the matrix only
    //   adds drive;
    //   blocking in a
    //   permanent fault
    //   is done later
    // matrix routing of group alarms and extra alarm sources
    logic [NUM_OUTPUTS-1:0] matrixTerm [NUM_GROUPS];
    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : g_matrix
            assign matrixTerm[g] = ({NUM_OUTPUTS{groupActive[g]}} & groupMatrixCfg[g])
                | ({NUM_OUTPUTS{extraAlarmIn[g]}} & extraMatrixCfg[g]);
        end
    endgenerate
    wire [NUM_OUTPUTS-1:0] matrixOut = matrixTerm[0] | matrixTerm[1] | matrixTerm[2];

    // health terms:
    // - supply fault
    //   covers aux loss
    //   and its bits
    // - a group only
    //   counts if chosen
    // any internal fault, supply check included
    wire supplyFault = hwFault[BIT_INTERNAL_VOLTAGE] | hwFault[BIT_LOW_SUPPLY] | ~auxSupplyOk;
    wire anyHwFault = |hwFault;
    // main functions lost: watchdog gave up, or boot test failed
    wire permanentNow = (wdState_q == WD_DEAD) | bootBad_q;
    // temporary condition: runtime fault seen while still operating
    wire tempNow = (anyHwFault | supplyFault) & ~permanentNow;
    // selected groups pull the fault-status relay down
    wire groupDrop = |(groupActive & groupToFault_q);
    wire healthy = auxSupplyOk & ~permanentNow & ~groupDrop & ~supplyFault;

    // phases:
    // run: kick clears
    //   the counter
    // restart: pulse
    //   to controller
    // wait: a kick
    //   returns to run
    // dead: held
    //   until rst
    // the counter is
    //   cleared entering
    //   run, restart and
    //   wait, so lengths are exact
    // limitation: a
    //   kick stuck high
    //   hides a hang
    // watchdog next state; a missed kick restarts, no kick within the wait window after it is permanent
    always_comb begin
        wdState_d = wdState_q;
        wdCount_d = wdCount_q + 32'h0000_0001;
        restart_d = 1'b0;
        case (wdState_q)
            WD_RUN: begin
                if (wdKick) begin
                    wdCount_d = '0;
                end else if (wdCount_q >= 32'(KICK_TIMEOUT - 1)) begin
                    wdState_d = WD_RESTART;      // controller inoperable
                    wdCount_d = '0;
                end
            end
            WD_RESTART: begin
                restart_d = 1'b1;                // hold controller in restart
                if (wdCount_q >= 32'(RESTART_PULSE - 1)) begin
                    wdState_d = WD_WAIT;
                    wdCount_d = '0;
                    // last cycle of the pulse still drives restart
                end
            end
            WD_WAIT: begin
                if (wdKick) begin
                    wdState_d = WD_RUN;          // controller came back
                    wdCount_d = '0;
                end else if (wdCount_q >= 32'(RESTART_WAIT - 1)) begin
                    wdState_d = WD_DEAD;         // restart failed
                end
            end
            default: begin
                wdCount_d = wdCount_q;           // stays dead until reset
            end
        endcase
    end

    // watchdog registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wdState_q <= WD_RUN;
            wdCount_q <= '0;
            restart_q <= 1'b0;
        end else begin
            wdState_q <= wdState_d;
            wdCount_q <= wdCount_d;
            restart_q <= restart_d;
        end
    end

    // fault-status selection; reset value leaves only group two linked
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            groupToFault_q <= GROUP_TO_FAULT_OUT_RESET;
        end else if (groupToFaultLoad) begin
            groupToFault_q <= groupToFaultCfg;
        end
    end

    // boot result is latched once the boot test finishes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bootBad_q <= 1'b0;
        end else if (bootTestDone & bootTestFail) begin
            bootBad_q <= 1'b1;
        end
    end

    // latch policy:
    // - set while the
    //   detector is high
    // - panel clear
    //   drops them, but
    //   a live detector
    //   sets them again
    // - aux loss sets
    //   the supply bit
    // latched diagnostics; a new fault wins over the panel clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            faultLatch_q <= '0;
            outFaultLatch_q <= '0;
            oddLatch_q <= 1'b0;
        end else begin
            faultLatch_q <= (panelReset ? '0 : faultLatch_q) | hwFault
                | {~auxSupplyOk, {(INTERNAL_FAULT_BITS-1){1'b0}}};
            outFaultLatch_q <= (panelReset ? '0 : outFaultLatch_q) | outputFault;
            oddLatch_q <= (panelReset ? 1'b0 : oddLatch_q) | unexpectedStatus;
        end
    end

    // events:
    // - on-event when
    //   the condition
    //   appears
    // - off-event when
    //   it goes
    // - valid is one
    //   cycle, not held
    // a permanent state
    //   masks the cause
    // temporary state tracking and event generation
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tempFault_q <= 1'b0;
            diagEvent <= '0;
        end else begin
            tempFault_q <= tempNow;
            diagEvent.valid <= tempNow ^ tempFault_q;
            // event code travels with every diagnostic event
            diagEvent.code <= tempNow ? TEMP_FAULT_ON_EVENT : TEMP_FAULT_OFF_EVENT;
        end
    end

    // read port:
    // - strobe taken
    //   at one edge
    // - data stands
    //   until the next
    //   strobe
    // - reads never
    //   clear a latch
    // - spare reads 0
    //   (index 2)
    // remote register read mux
    logic [REG_WIDTH-1:0] readMux;
    always_comb begin
        if (regAddr == REG_OUT_FAULT_LOW) begin
            readMux = {outFaultLatch_q[OUT_LOW_COUNT-1:0], 2'b00};
        end else if (regAddr == REG_OUT_FAULT_HIGH) begin
            readMux = {1'b0, outFaultLatch_q[NUM_OUTPUTS-1:OUT_LOW_COUNT]};
        end else if (regAddr == REG_INTERNAL_FAULT) begin
            // bit order fixed by the field constants
            readMux = {6'h00, faultLatch_q};
        end else begin
            readMux = REG_RESET;                 // third register reads as zero
        end
    end

    // read data is registered and held between reads
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regData <= REG_RESET;
        end else if (regRead) begin
            regData <= readMux;
        end
    end

    // output stage:
    // - protection and
    //   matrix are ORed
    // - permanent state
    //   forces all low
    // - fault relay
    //   drops with power
    //   the same way
    // output stage; all outputs come straight from flip-flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            faultStatusOutput <= 1'b0;
            digitalOutput <= '0;
            diagGroupAlarm <= '0;
            selfDiagSignal <= 1'b0;
            controllerRestart <= 1'b0;
            permanentFault <= 1'b0;
            indication <= '0;
        end else begin
            faultStatusOutput <= healthy;
            digitalOutput <= permanentNow ? '0 : (protectionOut | matrixOut);
            diagGroupAlarm <= groupActive;
            selfDiagSignal <= tempNow;
            controllerRestart <= restart_q;
            permanentFault <= permanentNow;
            indication.serviceLed <= permanentNow | oddLatch_q;
            indication.faultMessage <= permanentNow;
            indication.statusNotice <= oddLatch_q;
        end
    end

endmodule : relay_self_supervision
`default_nettype wire

// >>> relay_self_supervision_sva.sv
// assertion checker for the relay self-supervision block
`timescale 1ns/1ns
`default_nettype none

module relay_self_supervision_sva
    import self_supervision_pkg::*;
#(
    parameter int KICK_TIMEOUT = 8,  // watchdog timeout in cycles
    parameter int RESTART_PULSE = 2,  // restart pulse in cycles
    parameter int RESTART_WAIT = 16  // recovery window in cycles
) (
    input wire logic ref_clk,  // system clock
    input wire logic rst,  // sync reset
    input wire logic wdKick,  // controller alive
    input wire logic controllerRestart,  // restart pulse
    input wire logic permanentFault,  // permanent fault
    input wire logic auxSupplyOk,  // supply present
    input wire logic [INTERNAL_FAULT_BITS-1:0] hwFault,  // fault detectors
    input wire logic regRead,  // read strobe
    input wire logic [REG_WIDTH-1:0] regData,  // read data
    input wire logic faultStatusOutput,  // fault-status coil
    input wire logic [NUM_OUTPUTS-1:0] digitalOutput,  // output coils
    input wire logic selfDiagSignal,  // temporary fault signal
    input wire event_s diagEvent,  // event record
    input wire indication_s indication  // indications
);
    logic [31:0] pulseLen_q;  // length of the running restart pulse
    logic [31:0] idle_q;  // cycles since the last kick

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // counters: repetition cannot carry a parameter, so lengths are counted here
    always_ff @(posedge ref_clk) begin
        pulseLen_q <= (rst || !controllerRestart) ? '0 : pulseLen_q + 1;
        idle_q <= (rst || wdKick) ? '0 : idle_q + 1;
    end

    // a temporary fault starts while supply was steady and unit alive
    sequence tempRise;
        $rose(|hwFault) && auxSupplyOk && $past(auxSupplyOk) && !permanentFault;
    endsequence
    sequence tempFall;
        $fell(|hwFault) && auxSupplyOk && $past(auxSupplyOk) && !permanentFault;
    endsequence
    sequence onLogged;
        diagEvent.valid && diagEvent.code == TEMP_FAULT_ON_EVENT;
    endsequence
    sequence offLogged;
        diagEvent.valid && diagEvent.code == TEMP_FAULT_OFF_EVENT;
    endsequence

    AST_RESTART_LATE: assert property ($rose(controllerRestart) |-> idle_q >= KICK_TIMEOUT)
        else $error("restart raised before the kick timeout");
    AST_RESTART_LEN: assert property ($fell(controllerRestart) |-> pulseLen_q == RESTART_PULSE)
        else $error("restart pulse has the wrong length");
    AST_PERM_LATE: assert property ($rose(permanentFault) && idle_q > 0
        |-> idle_q >= KICK_TIMEOUT + RESTART_PULSE + RESTART_WAIT)
        else $error("permanent fault before the recovery window ran out");
    AST_PERM_BLOCK: assert property (permanentFault && $past(permanentFault)
        |-> digitalOutput == '0 && !faultStatusOutput)
        else $error("outputs driven during permanent fault");
    AST_SUPPLY_LOSS: assert property (!auxSupplyOk |=> !faultStatusOutput)
        else $error("fault-status stays energized without supply");
    AST_PERM_IND: assert property ($rose(permanentFault)
        |-> ##[0:2] (indication.serviceLed && indication.faultMessage))
        else $error("permanent fault not indicated");
    AST_TEMP_ON: assert property (tempRise |-> ##1 onLogged)
        else $error("missing on-event");
    AST_TEMP_OFF: assert property (tempFall |-> ##1 offLogged)
        else $error("missing off-event");
    AST_SELFDIAG: assert property ((|hwFault) && auxSupplyOk && !permanentFault
        |=> selfDiagSignal)
        else $error("matrix signal not set for temporary fault");
    AST_READ_HOLD: assert property (!regRead |=> $stable(regData))
        else $error("read data changed without a read");

endmodule : relay_self_supervision_sva

bind relay_self_supervision relay_self_supervision_sva #(
    .KICK_TIMEOUT(KICK_TIMEOUT),
    .RESTART_PULSE(RESTART_PULSE),
    .RESTART_WAIT(RESTART_WAIT)
) checker_inst (.ref_clk, .rst, .wdKick, .controllerRestart, .permanentFault, .auxSupplyOk,
    .hwFault, .regRead, .regData, .faultStatusOutput, .digitalOutput, .selfDiagSignal,
    .diagEvent, .indication);

`default_nettype wire

// >>> remote_reader.sv
// remote protocol master model that reads the diagnostic registers
`timescale 1ns/1ns
`default_nettype none

module remote_reader
    import self_supervision_pkg::*;
(
    input wire logic ref_clk,  // system clock
    output logic [1:0] regAddr,  // register index
    output logic regRead,  // read strobe
    input wire logic [REG_WIDTH-1:0] regData  // read data
);
    initial begin
        regAddr = 2'h0;
        regRead = 1'b0;
    end

    // one read: strobe taken at one edge, data sampled an edge later
    task automatic rd(input logic [1:0] a, output logic [REG_WIDTH-1:0] d);
        regAddr = a;
        regRead = 1'b1;
        @(posedge ref_clk);
        #1;
        regRead = 1'b0;
        regAddr = ~a;  // stale index must not matter once taken
        @(posedge ref_clk);
        #1;
        d = regData;
    endtask : rd
endmodule : remote_reader

`default_nettype wire

// >>> self_supervision_pkg.sv
// shared constants, types and register layout for the relay self-supervision block
package self_supervision_pkg;

    // digital outputs: t1..t8, a1..a5, t9..t24 give 29 controllable outputs
    localparam int NUM_OUTPUTS = 29;
    localparam int NUM_ALARMS = 16;               // supervision alarm sources
    localparam int NUM_GROUPS = 3;                // diagnostic alarm groups
    localparam int REG_WIDTH = 16;

    // register indices on the remote read port (no offsets printed)
    localparam logic [1:0] REG_OUT_FAULT_LOW = 2'h0;
    localparam logic [1:0] REG_OUT_FAULT_HIGH = 2'h1;
    localparam logic [1:0] REG_SPARE = 2'h2;      // third register, content not laid out
    localparam logic [1:0] REG_INTERNAL_FAULT = 2'h3;

    // field positions in the output fault registers
    localparam int OUT_LOW_FIRST_BIT = 2;         // bits 0 and 1 reserved
    localparam int OUT_LOW_COUNT = 14;            // outputs 0..13 land in bits 2..15
    localparam int OUT_HIGH_COUNT = 15;           // outputs 14..28 land in bits 0..14

    // field positions in the internal fault register
    localparam int BIT_INTERNAL_VOLTAGE = 0;
    localparam int BIT_BUS_BUFFER = 1;
    localparam int BIT_ORDER_CODE = 2;
    localparam int BIT_OPTION_CARD = 3;
    localparam int BIT_LOGIC_CONFIG = 4;
    localparam int BIT_ARC_IO_UNIT = 5;
    localparam int BIT_ARC_SENSOR = 6;
    localparam int BIT_QD_CARD = 7;
    localparam int BIT_ARC_BINARY_INPUT = 8;
    localparam int BIT_LOW_SUPPLY = 9;
    localparam int INTERNAL_FAULT_BITS = 10;

    // event codes
    localparam logic [7:0] TEMP_FAULT_ON_EVENT = 8'h38;   // code 56
    localparam logic [7:0] TEMP_FAULT_OFF_EVENT = 8'h39;  // code 57

    // reset values
    localparam logic [2:0] GROUP_TO_FAULT_OUT_RESET = 3'h2;  // only group 2 drives it
    localparam logic [REG_WIDTH-1:0] REG_RESET = 16'h0000;

    // watchdog timing
    localparam int KICK_TIMEOUT_US = 100;         // controller must kick within this
    localparam int RESTART_PULSE_US = 10;         // length of the restart pulse
    localparam int RESTART_WAIT_US = 1000;        // time allowed for the controller to return
    localparam int CLOCK_MHZ = 125;
    localparam int KICK_TIMEOUT_CYC = KICK_TIMEOUT_US * CLOCK_MHZ;
    localparam int RESTART_PULSE_CYC = RESTART_PULSE_US * CLOCK_MHZ;
    localparam int RESTART_WAIT_CYC = RESTART_WAIT_US * CLOCK_MHZ;

    // watchdog states, gray along run -> restart -> wait -> dead
    typedef enum logic [1:0] {
        WD_RUN = 2'b00,
        WD_RESTART = 2'b01,
        WD_WAIT = 2'b11,
        WD_DEAD = 2'b10
    } wd_state_e;

    // event record toward the event log
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } event_s;

    // local indication bundle
    typedef struct packed {
        logic serviceLed;
        logic faultMessage;
        logic statusNotice;
    } indication_s;

endpackage : self_supervision_pkg

// >>> tb_relay_self_supervision.sv
// self-checking testbench for the relay self-supervision block
`timescale 1ns/1ns
`default_nettype none

module tb_relay_self_supervision;
    import self_supervision_pkg::*;
    logic ref_clk = 0, rst = 1, wdKick = 1, auxSupplyOk = 1, bootTestDone = 0;
    logic bootTestFail = 0, unexpectedStatus = 0, groupToFaultLoad = 0, panelReset = 0;
    logic [INTERNAL_FAULT_BITS-1:0] hwFault = '0;  // fault detectors
    logic [NUM_OUTPUTS-1:0] outputFault = '0, protectionOut = 29'h0100_0000;
    logic [NUM_ALARMS-1:0] alarmIn = '0;  // alarm sources
    logic [NUM_GROUPS-1:0] extraAlarmIn = '0, groupToFaultCfg = '0, diagGroupAlarm;
    logic [2*NUM_ALARMS-1:0] alarmGroupCfg = 32'h0000_0039;  // alarm0..2 to groups 1..3
    logic [NUM_OUTPUTS-1:0] gm [NUM_GROUPS], em [NUM_GROUPS], digitalOutput, of;
    logic controllerRestart, permanentFault, faultStatusOutput, selfDiagSignal, regRead;
    wire logic [1:0] regAddr;  // index from the master model
    logic [REG_WIDTH-1:0] regData;  // read data
    event_s diagEvent;  // event record
    indication_s indication;  // indications
    int error_cnt = 0, cmp_count = 0, cyc = 0;

    relay_self_supervision #(.KICK_TIMEOUT(8), .RESTART_PULSE(2), .RESTART_WAIT(16)) DUT (
        .ref_clk, .rst, .wdKick, .controllerRestart, .permanentFault, .auxSupplyOk, .hwFault,
        .bootTestDone, .bootTestFail, .unexpectedStatus, .outputFault, .alarmIn,
        .extraAlarmIn, .alarmGroupCfg, .groupToFaultCfg, .groupToFaultLoad,
        .groupMatrixCfg(gm), .extraMatrixCfg(em), .protectionOut, .panelReset, .regAddr,
        .regRead, .regData, .faultStatusOutput, .digitalOutput, .diagGroupAlarm,
        .selfDiagSignal, .diagEvent, .indication);
    remote_reader master (.ref_clk, .regAddr, .regRead, .regData);

    always #4 ref_clk = ~ref_clk;
    // hang guard: the whole sequence needs well under this
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic rchk(input logic [1:0] a, input logic [15:0] e);
        logic [15:0] d;
        master.rd(a, d);
        chk(d, e);
    endtask : rchk
    // front panel reset pulse clears the latched bits
    task automatic clr;
        panelReset = 1'b1;
        step(1);
        panelReset = 1'b0;
        step(1);
    endtask : clr
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    initial begin
        for (int g = 0; g < NUM_GROUPS; g++) begin
            gm[g] = 29'h0000_0002 << (g * 9);
            em[g] = 29'h0010_0000 << g;
        end
        step(5);
        rst = 1'b0;
        bootTestDone = 1'b1;
        step(1);
        bootTestDone = 1'b0;
        step(3);
        for (int a = 0; a < 4; a++) rchk(a[1:0], REG_RESET);
        chk(faultStatusOutput, 1'b1);
        $display("test reset done");
        // each internal detector lands in its own bit and is latched
        for (int b = 0; b < INTERNAL_FAULT_BITS; b++) begin
            hwFault = 10'h001 << b;
            step(1);
            chk(diagEvent, {1'b1, TEMP_FAULT_ON_EVENT});
            step(2);
            chk(selfDiagSignal, 1'b1);
            hwFault = '0;
            step(1);
            chk(diagEvent, {1'b1, TEMP_FAULT_OFF_EVENT});
            step(2);
            rchk(REG_INTERNAL_FAULT, 16'h0001 << b);
            clr();
            rchk(REG_INTERNAL_FAULT, 16'h0000);
        end
        $display("test internal done");
        for (int p = 0; p < 2; p++) begin
            of = p ? 29'h0AAA_AAAA : 29'h1555_5555;
            outputFault = of;
            step(2);
            outputFault = '0;
            step(1);
            rchk(REG_OUT_FAULT_LOW, {of[13:0], 2'b00});
            rchk(REG_OUT_FAULT_HIGH, {1'b0, of[28:14]});
            rchk(REG_SPARE, 16'h0000);
            clr();
        end
        $display("test output faults done");
        // alarm 3 has no group and must stay invisible
        for (int g = 0; g < NUM_GROUPS; g++) begin
            alarmIn = (16'h0001 << g) | 16'h0008;
            extraAlarmIn = 3'h1 << g;
            step(3);
            chk(diagGroupAlarm, 3'h1 << g);
            chk(faultStatusOutput, g != 1);
            chk(digitalOutput, protectionOut | gm[g] | em[g]);
            alarmIn = '0;
            extraAlarmIn = '0;
            clr();
        end
        groupToFaultCfg = 3'h1;
        groupToFaultLoad = 1'b1;
        step(1);
        groupToFaultLoad = 1'b0;
        alarmIn = 16'h0001;
        step(3);
        chk(faultStatusOutput, 1'b0);
        alarmIn = '0;
        clr();
        $display("test groups done");
        auxSupplyOk = 1'b0;
        step(2);
        chk(faultStatusOutput, 1'b0);
        auxSupplyOk = 1'b1;
        step(3);
        chk(faultStatusOutput, 1'b1);
        rchk(REG_INTERNAL_FAULT, 16'h0200);
        clr();
        unexpectedStatus = 1'b1;
        step(1);
        unexpectedStatus = 1'b0;
        step(2);
        chk(indication.serviceLed & indication.statusNotice, 1'b1);
        $display("test supply done");
        // first outage recovers on a kick, the second one is fatal
        wdKick = 1'b0;
        for (int i = 0; i < 40 && controllerRestart !== 1'b1; i++) step(1);
        chk(controllerRestart, 1'b1);
        wdKick = 1'b1;
        step(40);
        chk(permanentFault, 1'b0);
        wdKick = 1'b0;
        for (int i = 0; i < 100 && permanentFault !== 1'b1; i++) step(1);
        step(1);
        chk(permanentFault, 1'b1);
        chk(digitalOutput, 29'h0000_0000);
        chk(faultStatusOutput, 1'b0);
        chk(indication.faultMessage, 1'b1);
        $display("test watchdog done");
        wdKick = 1'b1;
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        bootTestDone = 1'b1;
        bootTestFail = 1'b1;
        step(1);
        bootTestDone = 1'b0;
        bootTestFail = 1'b0;
        step(3);
        chk(permanentFault, 1'b1);
        chk(digitalOutput, 29'h0000_0000);
        $display("test boot done");
        end_of_test();
    end
endmodule : tb_relay_self_supervision

`default_nettype wire
